// >>> design/tpoc_pkg.sv
// Purpose: Shared constants and types for the trace port output configuration block.
// Assumes: One core clock at 50 MHz; debug control pins arrive from another clock domain.
// Notes:   Control word field positions and reset values live here and nowhere else.
package tpoc_pkg;

	////////////////////////////////////////////////////////////////////////////////
	// Widths of the trace streams, the control word and the option straps.
	localparam int STATUS_W = 3;
	localparam int PACKET_W = 16;
	localparam int CTRL_W   = 32;
	localparam int STRAP_W  = 9;

	// Field positions inside the trace control word.
	localparam int CTRL_PWRDN_BIT  = 0;
	localparam int CTRL_HALF_BIT   = 1;
	localparam int CTRL_WIDTH_LSB  = 4;
	localparam int CTRL_WIDTH_MSB  = 6;
	localparam int CTRL_ENABLE_BIT = 11;
	localparam int CTRL_FMT_LSB    = 16;
	localparam int CTRL_FMT_MSB    = 17;

	// Option strap positions.
	localparam int STRAP_HALF_BIT  = 3;
	localparam int STRAP_WIDTH_MSB = 2;

	// Control word after reset: powered down, port off, four-bit port, normal format.
	localparam logic [CTRL_W-1:0] CTRL_RESET = 32'h0000_0001;

	// Pipeline status shown while no trace word is available.
	localparam logic [STATUS_W-1:0] STATUS_IDLE = 3'h0;

	// Synchroniser depth for pin inputs.
	localparam int SYNC_STAGES = 3;

	// Debug clock period in ns and core clock period in ns.
	localparam int DBG_CLK_NS  = 160;
	localparam int CORE_CLK_NS = 20;
	// Core cycles per debug clock period, rounded down as a longest time.
	localparam int DBG_CLK_CYC = DBG_CLK_NS / CORE_CLK_NS;

	////////////////////////////////////////////////////////////////////////////////
	// Port width selections.
	typedef enum logic [2:0]
	{
		TPOC_WIDTH_4  = 3'b000,
		TPOC_WIDTH_8  = 3'b001,
		TPOC_WIDTH_16 = 3'b010
	} tpoc_width_type;

	// Port format selections.
	typedef enum logic [1:0]
	{
		TPOC_FMT_NORMAL = 2'b00,
		TPOC_FMT_MUX    = 2'b01,
		TPOC_FMT_DEMUX  = 2'b10
	} tpoc_format_type;

	// One cycle of trace output.
	typedef struct packed
	{
		logic [STATUS_W-1:0] status;
		logic                sync;
		logic [PACKET_W-1:0] packet;
	} tpoc_word_type;

	localparam int WORD_W = $bits(tpoc_word_type);

	// Packet lane mask for a width selection; codes above sixteen bits fall back to four.
	function automatic logic [PACKET_W-1:0] tpoc_lane_mask(input logic [2:0] sel);
		logic [PACKET_W-1:0] m;
		m = 16'h000F;
		if (sel == TPOC_WIDTH_8)
		begin
			m = 16'h00FF;
		end
		else if (sel == TPOC_WIDTH_16)
		begin
			m = 16'hFFFF;
		end
		return m;
	endfunction : tpoc_lane_mask

endpackage : tpoc_pkg

// >>> design/tpoc_fifo.sv
// Purpose: Small trace word FIFO with a registered read port.
// Assumes: Single clock, synchronous active-low reset, DEPTH a power of two.
// Notes:   The output register adds one word of slack beyond DEPTH.
`timescale 1ns/1ps
module tpoc_fifo
	import tpoc_pkg::*;
#(
	parameter int WIDTH = 20,
	parameter int DEPTH = 16
)
(
	// Clock and reset.
	input  wire logic             i_clock,
	input  wire logic             i_nrst,
	// Fill side.
	input  wire logic             i_wr_valid,
	input  wire logic [WIDTH-1:0] i_wr_data,
	output logic                  o_wr_ready,
	// Drain side.
	output logic                  o_rd_valid,
	output logic      [WIDTH-1:0] o_rd_data,
	input  wire logic             i_rd_ready
);

	localparam int AW = $clog2(DEPTH);

	////////////////////////////////////////////////////////////////////////////////
	// Refuse depths the pointer arithmetic cannot serve.
	generate
		if (DEPTH < 2 || (DEPTH & (DEPTH - 1)) != 0 || WIDTH < 1)
		begin : g_bad
			$error("tpoc_fifo needs a power-of-two DEPTH of at least two");
		end
	endgenerate

	logic [WIDTH-1:0] mem_r [DEPTH];
	logic [AW:0]      wptr_r;
	logic [AW:0]      rptr_r;
	logic             out_valid_r;
	logic [WIDTH-1:0] out_data_r;

	// Full and empty from the pointers, with the wrap bit telling them apart.
	wire logic empty  = (wptr_r == rptr_r);
	wire logic full   = (wptr_r[AW] != rptr_r[AW]) && (wptr_r[AW-1:0] == rptr_r[AW-1:0]);
	wire logic push   = i_wr_valid && !full;
	wire logic reload = !empty && (!out_valid_r || i_rd_ready);

	assign o_wr_ready = !full;
	assign o_rd_valid = out_valid_r;
	assign o_rd_data  = out_data_r;

	////////////////////////////////////////////////////////////////////////////////
	// Storage has no reset; only the pointers and the output valid flag carry control state.
	always_ff @(posedge i_clock)
	begin
		if (push)
		begin
			mem_r[wptr_r[AW-1:0]] <= i_wr_data;
		end
	end

	// Pointers advance on accepted pushes and on reloads of the output register.
	always_ff @(posedge i_clock)
	begin
		if (!i_nrst)
		begin
			wptr_r <= '0;
			rptr_r <= '0;
		end
		else
		begin
			wptr_r <= push ? wptr_r + 1'b1 : wptr_r;
			rptr_r <= reload ? rptr_r + 1'b1 : rptr_r;
		end
	end

	// Read data comes out of a register so the drain side sees no memory path.
	always_ff @(posedge i_clock)
	begin
		if (!i_nrst)
		begin
			out_valid_r <= 1'b0;
			out_data_r  <= '0;
		end
		else if (reload)
		begin
			out_valid_r <= 1'b1;
			out_data_r  <= mem_r[rptr_r[AW-1:0]];
		end
		else if (i_rd_ready)
		begin
			out_valid_r <= 1'b0;
		end
	end

endmodule : tpoc_fifo

// >>> design/tpoc_top.sv
// Purpose: Trace port output stage and configuration outputs of the trace macrocell.
// Assumes: Debug control pins change on their own clock and hold data across its rising edge.
// Notes:   Pin sharing, format muxing and the exported clock are built outside this block.
`timescale 1ns/1ps

module tpoc_top
	import tpoc_pkg::*;
#(
	parameter int FIFO_DEPTH = 16
)
(
	// Clock and reset.
	input  wire logic                i_clock,
	input  wire logic                i_nrst,
	// Option straps from tie cells.
	input  wire logic [STRAP_W-1:0]  i_option_straps,
	// Debug control write pins, on the debugger's clock.
	input  wire logic                i_dbg_clk,
	input  wire logic                i_dbg_wr,
	input  wire logic [CTRL_W-1:0]   i_dbg_data,
	// Trace words from the trace generator.
	input  wire logic                i_trace_valid,
	input  wire tpoc_word_type       i_trace_word,
	output logic                     o_trace_ready,
	// Trace output streams.
	output logic [STATUS_W-1:0]      o_pipeline_status_bus,
	output logic                     o_trace_sync_flag,
	output logic [PACKET_W-1:0]      o_trace_packet_bus,
	// Configuration outputs for chip-level pin logic.
	output logic                     o_trace_port_enable,
	output logic [2:0]               o_port_width_select,
	output logic [1:0]               o_port_format_select,
	output logic                     o_half_rate_output,
	output logic                     o_power_down_output,
	// State for debug software to read.
	output logic [STRAP_W-1:0]       o_option_straps,
	output logic [CTRL_W-1:0]        o_ctrl_readback
);

	localparam int PIN_W = 2 + CTRL_W + STRAP_W;

	////////////////////////////////////////////////////////////////////////////////
	// Refuse a buffer too shallow to ride out a debugger write.
	generate
		if (FIFO_DEPTH < 2)
		begin : g_bad
			$error("tpoc_top needs FIFO_DEPTH of at least two");
		end
	endgenerate

	////////////////////////////////////////////////////////////////////////////////
	// Pin synchronisers: three stages, a change is taken once stages two and three agree.
	logic [PIN_W-1:0] s1_r;
	logic [PIN_W-1:0] s2_r;
	logic [PIN_W-1:0] s3_r;
	logic [PIN_W-1:0] pin_r;
	logic [PIN_W-1:0] pin_nxt;
	logic             dbg_clk_prev_r;

	wire logic [PIN_W-1:0] pin_raw = {i_dbg_clk, i_dbg_wr, i_dbg_data, i_option_straps};

	// Bitwise agreement filter: take stage two where it matches stage three, else hold.
	assign pin_nxt = (s2_r & s3_r) | (pin_r & (s2_r | s3_r));

	// Chain stays short: only stage two reads stage one.
	always_ff @(posedge i_clock)
	begin
		if (!i_nrst)
		begin
			s1_r  <= '0;
			s2_r  <= '0;
			s3_r  <= '0;
			pin_r <= '0;
		end
		else
		begin
			s1_r  <= pin_raw;
			s2_r  <= s1_r;
			s3_r  <= s2_r;
			pin_r <= pin_nxt;
		end
	end

	// Filtered pin fields.
	wire logic                dbg_clk_f  = pin_r[PIN_W-1];
	wire logic                dbg_wr_f   = pin_r[PIN_W-2];
	wire logic [CTRL_W-1:0]   dbg_data_f = pin_r[STRAP_W +: CTRL_W];
	wire logic [STRAP_W-1:0]  straps_f   = pin_r[STRAP_W-1:0];

	// A debug write lands on a filtered rising edge of the debug clock.
	wire logic dbg_edge = dbg_clk_f && !dbg_clk_prev_r;
	wire logic ctrl_load = dbg_edge && dbg_wr_f;

	always_ff @(posedge i_clock)
	begin
		if (!i_nrst)
		begin
			dbg_clk_prev_r <= 1'b0;
		end
		else
		begin
			dbg_clk_prev_r <= dbg_clk_f;
		end
	end

	////////////////////////////////////////////////////////////////////////////////
	// Trace control word; reset leaves the port off and a four-bit port chosen.
	logic [CTRL_W-1:0]  ctrl_r;
	logic [STRAP_W-1:0] straps_r;

	always_ff @(posedge i_clock)
	begin
		if (!i_nrst)
		begin
			ctrl_r <= CTRL_RESET;
		end
		else if (ctrl_load)
		begin
			ctrl_r <= dbg_data_f;
		end
	end

	// Straps are caught after reset release, never by the reset itself.
	always_ff @(posedge i_clock)
	begin
		if (!i_nrst)
		begin
			straps_r <= '0;
		end
		else
		begin
			straps_r <= straps_f;
		end
	end

	////////////////////////////////////////////////////////////////////////////////
	// Configuration outputs decoded from the control word.
	wire logic       enable_bit = ctrl_r[CTRL_ENABLE_BIT];
	wire logic       pwrdn_bit  = ctrl_r[CTRL_PWRDN_BIT];
	wire logic [2:0] width_sel  = ctrl_r[CTRL_WIDTH_MSB:CTRL_WIDTH_LSB];
	wire logic [1:0] format_sel = ctrl_r[CTRL_FMT_MSB:CTRL_FMT_LSB];
	// Half rate only in normal format, and only where the straps say the chip has it.
	wire logic       half_ok    = (format_sel == TPOC_FMT_NORMAL) && straps_r[STRAP_HALF_BIT];

	assign o_trace_port_enable  = enable_bit;
	assign o_port_width_select  = width_sel;
	assign o_port_format_select = format_sel;
	assign o_half_rate_output   = ctrl_r[CTRL_HALF_BIT] && half_ok;
	assign o_power_down_output  = pwrdn_bit;
	assign o_option_straps      = straps_r;
	assign o_ctrl_readback      = ctrl_r;

	////////////////////////////////////////////////////////////////////////////////
	// Trace word buffer; a full buffer stalls the trace generator.
	logic             fifo_rd_valid;
	logic [WORD_W-1:0] fifo_rd_data;

	// Drain every cycle unless powered down; a disabled port drains and drops words.
	wire logic fifo_pop = !pwrdn_bit;

	tpoc_fifo #(
		.WIDTH (WORD_W),
		.DEPTH (FIFO_DEPTH)
	) u_fifo (
		.i_clock    (i_clock),
		.i_nrst     (i_nrst),
		.i_wr_valid (i_trace_valid),
		.i_wr_data  (i_trace_word),
		.o_wr_ready (o_trace_ready),
		.o_rd_valid (fifo_rd_valid),
		.o_rd_data  (fifo_rd_data),
		.i_rd_ready (fifo_pop)
	);

	////////////////////////////////////////////////////////////////////////////////
	// Output stage: a live word when the port is on and not powered down, otherwise idle levels.
	tpoc_word_type out_r;
	tpoc_word_type out_nxt;

	wire tpoc_word_type head = tpoc_word_type'(fifo_rd_data);
	// Lanes above the selected width stay low so shared pins see no trace toggling.
	wire logic [PACKET_W-1:0] lane_mask = tpoc_lane_mask(width_sel);
	wire logic live = fifo_rd_valid && fifo_pop && enable_bit;

	assign out_nxt.status = live ? head.status : STATUS_IDLE;
	assign out_nxt.sync   = live ? head.sync : 1'b0;
	assign out_nxt.packet = live ? (head.packet & lane_mask) : '0;

	always_ff @(posedge i_clock)
	begin
		if (!i_nrst)
		begin
			out_r <= '{status: STATUS_IDLE, sync: 1'b0, packet: '0};
		end
		else
		begin
			out_r <= out_nxt;
		end
	end

	assign o_pipeline_status_bus = out_r.status;
	assign o_trace_sync_flag     = out_r.sync;
	assign o_trace_packet_bus    = out_r.packet;

	////////////////////////////////////////////////////////////////////////////////
	// Checks on the configuration and output behaviour.
	default clocking cb @(posedge i_clock); endclocking
	default disable iff (!i_nrst);

	property p_reset_config;
		$past(!i_nrst) |-> (!o_trace_port_enable && o_port_width_select == 3'h0);
	endproperty
	a_reset_config: assert property (p_reset_config)
		else $error("port not off with four-bit width after reset");

	property p_enable_written;
		ctrl_load |=> (o_trace_port_enable == $past(dbg_data_f[CTRL_ENABLE_BIT]))
			&& (o_port_width_select == $past(dbg_data_f[CTRL_WIDTH_MSB:CTRL_WIDTH_LSB]));
	endproperty
	a_enable_written: assert property (p_enable_written)
		else $error("enable or width did not follow control write");

	property p_format_mirror;
		ctrl_load |=> o_port_format_select == $past(dbg_data_f[CTRL_FMT_MSB:CTRL_FMT_LSB]);
	endproperty
	a_format_mirror: assert property (p_format_mirror)
		else $error("format output does not mirror control bits");

	property p_half_rate_normal_only;
		o_half_rate_output |-> (o_port_format_select == 2'h0 && o_option_straps[3]);
	endproperty
	a_half_rate_normal_only: assert property (p_half_rate_normal_only)
		else $error("half rate asserted outside normal format");

	property p_disabled_idle;
		!o_trace_port_enable |=> (o_trace_packet_bus == 16'h0000 && !o_trace_sync_flag);
	endproperty
	a_disabled_idle: assert property (p_disabled_idle)
		else $error("trace pins active while port disabled");

	property p_width_mask;
		($past(o_port_width_select) == 3'h0) |-> (o_trace_packet_bus[15:4] == 12'h000);
	endproperty
	a_width_mask: assert property (p_width_mask)
		else $error("packet lanes above four bits toggled");

	property p_word_passes;
		(fifo_rd_valid && o_trace_port_enable && !o_power_down_output)
			|=> o_pipeline_status_bus == $past(head.status);
	endproperty
	a_word_passes: assert property (p_word_passes)
		else $error("trace word status not emitted");

	property p_dbg_edge_once;
		dbg_edge |=> !dbg_edge [*2];
	endproperty
	a_dbg_edge_once: assert property (p_dbg_edge_once)
		else $error("debug clock edge seen twice in a row");

	// Powered down holds the buffer, so the pins stay at idle levels.
	property p_power_down_quiet;
		o_power_down_output |=> (o_pipeline_status_bus == STATUS_IDLE) && !o_trace_sync_flag;
	endproperty
	a_power_down_quiet: assert property (p_power_down_quiet)
		else $error("trace pins active while powered down");

	// Where half rate is allowed it must follow the control bit, so it cannot stick.
	property p_half_rate_follows;
		(o_port_format_select == 2'h0) && o_option_straps[STRAP_HALF_BIT]
			|-> (o_half_rate_output == o_ctrl_readback[CTRL_HALF_BIT]);
	endproperty
	a_half_rate_follows: assert property (p_half_rate_follows)
		else $error("half rate does not follow control bit in normal format");

	c_port_on:   cover property (ctrl_load ##1 o_trace_port_enable);
	c_width_8:   cover property (o_trace_port_enable && o_port_width_select == 3'h1);
	c_half_rate: cover property (o_half_rate_output);
	c_demux:     cover property (o_port_format_select == 2'h2 && o_trace_port_enable);
	c_stall:     cover property (i_trace_valid && !o_trace_ready);

endmodule : tpoc_top

// >>> tb/tpoc_probe.sv
// Purpose: Capture probe model that samples the trace output pins.
// Assumes: Pins launch on the rising core edge; capture is half a period later.
// Notes:   Idle cycles (idle status, no sync, no packet) are not recorded.
`timescale 1ns/1ps
module tpoc_probe
	import tpoc_pkg::*;
(
	// Core clock, doubling as the exported trace clock.
	input  wire logic                i_clock,
	// Trace pins.
	input  wire logic [STATUS_W-1:0] i_status,
	input  wire logic                i_sync,
	input  wire logic [PACKET_W-1:0] i_packet,
	// Configuration outputs that steer the chip's pin sharing.
	input  wire logic                i_port_enable,
	input  wire logic [2:0]          i_width_select,
	// Data pins claimed by this processor and left for a second one.
	output int                       o_data_pins,
	output int                       o_other_pins
);
	////////////////////////////////////////////////////////////////////////////////
	tpoc_word_type cap_q[$];
	wire           busy_w;

	// Anything but a clean idle word counts, so unknowns are recorded too.
	assign busy_w = (i_status !== STATUS_IDLE) || (i_sync !== 1'b0) || (i_packet !== 16'h0000);

	// The system side supplies the clock; sampling on the falling edge keeps the
	// capture half a period away from the launch, so data is stable around it.
	// Format mapping is left to chip logic; the probe sees the unmapped streams.
	always @(negedge i_clock)
	begin
		if (busy_w)
		begin
			cap_q.push_back({i_status, i_sync, i_packet});
		end
	end

	////////////////////////////////////////////////////////////////////////////////
	// Pin sharing: status, sync and the low four lanes never leave trace duty.
	always_comb
	begin
		o_data_pins = 8;
		if (i_port_enable && (i_width_select == TPOC_WIDTH_8))
		begin
			o_data_pins = 12;
		end
		else if (i_port_enable && (i_width_select == TPOC_WIDTH_16))
		begin
			o_data_pins = 20;
		end
	end

	// A second processor takes what is left of the twenty shared data pins.
	assign o_other_pins = 20 - o_data_pins;
endmodule : tpoc_probe

// >>> tb/tpoc_top_test.sv
// Purpose: Self-checking bench for the trace port output configuration block.
// Assumes: Debug clock stands low between writes and runs at 160 ns within them.
// Notes:   A two-word buffer keeps the fill and refusal test short.
`timescale 1ns/1ps
module tpoc_top_test
	import tpoc_pkg::*;
;
	localparam int DEPTH = 2;

	logic                clock = 1'b0;
	logic                nrst = 1'b0;
	logic [STRAP_W-1:0]  straps = 9'h0FA;
	logic                dbg_clk = 1'b0;
	logic                dbg_wr = 1'b0;
	logic [CTRL_W-1:0]   dbg_data = 32'h0000_0000;
	logic                tv = 1'b0;
	tpoc_word_type       tw = '0;
	logic                rdy, en, hr, pd;
	logic [STATUS_W-1:0] st;
	logic                sy;
	logic [PACKET_W-1:0] pk, msk;
	logic [2:0]          wd;
	logic [1:0]          fm;
	logic [STRAP_W-1:0]  so;
	logic [CTRL_W-1:0]   rb;
	int                  error_cnt = 0;
	int                  total_checks = 0;
	int                  acc;
	int                  exp_pins;
	int                  pins;
	int                  other;
	logic                ok;

	tpoc_top #(.FIFO_DEPTH(DEPTH)) i_dut (.i_clock(clock), .i_nrst(nrst),
		.i_option_straps(straps), .i_dbg_clk(dbg_clk), .i_dbg_wr(dbg_wr),
		.i_dbg_data(dbg_data), .i_trace_valid(tv), .i_trace_word(tw), .o_trace_ready(rdy),
		.o_pipeline_status_bus(st), .o_trace_sync_flag(sy), .o_trace_packet_bus(pk),
		.o_trace_port_enable(en), .o_port_width_select(wd), .o_port_format_select(fm),
		.o_half_rate_output(hr), .o_power_down_output(pd), .o_option_straps(so),
		.o_ctrl_readback(rb));

	// One probe per macrocell, and one macrocell per processor.
	tpoc_probe i_probe (.i_clock(clock), .i_status(st), .i_sync(sy), .i_packet(pk),
		.i_port_enable(en), .i_width_select(wd),
		.o_data_pins(pins), .o_other_pins(other));

	// Free-running core clock.
	always #10 clock = ~clock;

	////////////////////////////////////////////////////////////////////////////////
	task automatic final_report;
		if ((error_cnt == 0) && (total_checks > 0))
			$display("bench passed");
		else
			$display("bench failed");
		$finish;
	endtask : final_report

	task automatic chk(input logic [31:0] got, input logic [31:0] exp, input string msg);
		total_checks++;
		if (got !== exp)
		begin
			error_cnt++;
			$display("[ERR] %0t %s got %h exp %h", $time, msg, got, exp);
		end
	endtask : chk

	task automatic tick(input int n);
		repeat (n) @(posedge clock);
		#1;
	endtask : tick

	// One debug clock period; data is held well past the rise to survive the filter.
	task automatic dbg_write(input logic wr, input logic [31:0] d);
		tick(1);
		dbg_wr = wr;
		dbg_data = d;
		tick(4);
		dbg_clk = 1'b1;
		tick(4);
		dbg_clk = 1'b0;
		tick(4);
		dbg_wr = 1'b0;
		tick(6);
	endtask : dbg_write

	// Offers one word; valid stays up so back-to-back calls never toggle it.
	task automatic push(input tpoc_word_type w, output logic taken);
		tv = 1'b1;
		tw = w;
		@(negedge clock);
		taken = rdy;
		@(posedge clock);
		#1;
	endtask : push

	function automatic logic [31:0] cw(input logic p, input logic h, input logic [2:0] w,
		input logic e, input logic [1:0] f);
		logic [31:0] v;
		v = 32'h0000_0000;
		v[CTRL_PWRDN_BIT] = p;
		v[CTRL_HALF_BIT] = h;
		v[CTRL_WIDTH_MSB:CTRL_WIDTH_LSB] = w;
		v[CTRL_ENABLE_BIT] = e;
		v[CTRL_FMT_MSB:CTRL_FMT_LSB] = f;
		return v;
	endfunction : cw

	task automatic chk_reset;
		chk(32'(en), 32'h0, "enable after reset");
		chk(32'(wd), 32'h0, "width after reset");
		chk(32'(pd), 32'h1, "power down after reset");
		chk(rb, 32'h0000_0001, "control after reset");
		chk(32'(rdy), 32'h1, "ready after reset");
	endtask : chk_reset

	////////////////////////////////////////////////////////////////////////////////
	// Watchdog, sized at over twenty times the expected run of a few hundred cycles.
	initial
	begin
		#200000;
		error_cnt++;
		final_report();
	end

	// Main sequence: reset, configuration sweep with streams, refusal, back-pressure.
	initial
	begin
		tick(5);
		nrst = 1'b1;
		chk_reset();
		tick(10);
		chk(32'(so), 32'h0FA, "strap readback");
		for (int wi = 0; wi < 3; wi++)
		begin
			msk = (wi == 1) ? 16'h00FF : ((wi == 2) ? 16'hFFFF : 16'h000F);
			exp_pins = (wi == 1) ? 12 : ((wi == 2) ? 20 : 8);
			for (int fi = 0; fi < 3; fi++)
			begin
				dbg_write(1'b1, cw(1'b0, 1'b1, 3'(wi), 1'b1, 2'(fi)));
				chk(32'(en), 32'h1, "enable");
				chk(32'(wd), 32'(wi), "width");
				chk(32'(fm), 32'(fi), "format");
				chk(32'(hr), 32'(fi == 0), "half rate");
				chk(32'(pd), 32'h0, "power down");
				chk(32'(pins), 32'(exp_pins), "trace pins");
				chk(32'(other), 32'(20 - exp_pins), "other pins");
				i_probe.cap_q.delete();
				for (int k = 1; k < 4; k++)
				begin
					push({3'(k + fi), k[0], 16'hA5C0 | 16'(k)}, ok);
				end
				tv = 1'b0;
				tick(8);
				chk(32'(i_probe.cap_q.size()), 32'h3, "word count");
				for (int k = 1; k < 4; k++)
				begin
					chk(32'(i_probe.cap_q[k - 1]), 32'({3'(k + fi), k[0],
						(16'hA5C0 | 16'(k)) & msk}), "word");
				end
			end
		end
		dbg_write(1'b0, cw(1'b1, 1'b0, 3'h1, 1'b0, 2'h1));
		chk(rb, cw(1'b0, 1'b1, 3'h2, 1'b1, 2'h2), "ignored write");
		dbg_write(1'b1, cw(1'b1, 1'b0, 3'h2, 1'b0, 2'h0));
		chk(32'(pd), 32'h1, "power down set");
		i_probe.cap_q.delete();
		acc = 0;
		ok = 1'b1;
		while (ok && (acc < 10))
		begin
			push({3'h5, 1'b0, 16'(acc)}, ok);
			acc += int'(ok);
		end
		tv = 1'b0;
		chk(32'(acc), 32'(DEPTH + 1), "fill count");
		chk(32'(rdy), 32'h0, "ready while full");
		chk(32'(i_probe.cap_q.size()), 32'h0, "nothing out while down");
		dbg_write(1'b1, cw(1'b0, 1'b0, 3'h2, 1'b1, 2'h0));
		chk(32'(i_probe.cap_q.size()), 32'(DEPTH + 1), "drained count");
		chk(32'(i_probe.cap_q[DEPTH]), 32'({3'h5, 1'b0, 16'(DEPTH)}), "drain order");
		dbg_write(1'b1, cw(1'b0, 1'b0, 3'h2, 1'b0, 2'h0));
		chk(32'(pins), 32'h8, "pins back to chip");
		i_probe.cap_q.delete();
		for (int k = 0; k < 4; k++)
		begin
			push({3'h6, 1'b1, 16'h1234}, ok);
			chk(32'(ok), 32'h1, "disabled port drains");
		end
		tv = 1'b0;
		tick(8);
		chk(32'(i_probe.cap_q.size()), 32'h0, "disabled port idle");
		nrst = 1'b0;
		tick(2);
		nrst = 1'b1;
		chk_reset();
		final_report();
	end
endmodule : tpoc_top_test
